// File: verilog/pwmcc_consts.svh
// register offsets, field positions, reset values and codes of the pwm clock/channel control
`ifndef PWMCC_CONSTS_SVH
`define PWMCC_CONSTS_SVH

`define PWMCC_OFF_MR       8'h00
`define PWMCC_OFF_ENA      8'h04
`define PWMCC_OFF_DIS      8'h08
`define PWMCC_OFF_SR       8'h0C
`define PWMCC_OFF_IER      8'h10
`define PWMCC_OFF_IDR      8'h14
`define PWMCC_OFF_IMR      8'h18
`define PWMCC_OFF_ISR      8'h1C

`define PWMCC_FACT_A_LSB   0
`define PWMCC_PRE_A_LSB    8
`define PWMCC_FACT_B_LSB   16
`define PWMCC_PRE_B_LSB    24
`define PWMCC_FACTOR_W     8
`define PWMCC_PRESCALE_W   4
`define PWMCC_PRE_CNT_W    10
`define PWMCC_PRE_MAX      4'hA
`define PWMCC_MR_MASK      32'h0FFF0FFF

`define PWMCC_MR_RST       32'h00000000
`define PWMCC_CH_RST       4'h0

`define PWMCC_RESP_OKAY    2'h0
`define PWMCC_RESP_SLVERR  2'h2

`endif

// File: verilog/pwmcc_pkg.sv
// types shared by the pwm clock/channel control modules
`include "pwmcc_consts.svh"
package pwmcc_pkg;
  typedef logic [`PWMCC_FACTOR_W-1:0]   pwmcc_factor_t;
  typedef logic [`PWMCC_PRESCALE_W-1:0] pwmcc_prescale_t;
  typedef logic [`PWMCC_PRE_CNT_W-1:0]  pwmcc_pre_cnt_t;
  typedef logic [31:0]                  pwmcc_word_t;
  typedef logic [1:0]                   pwmcc_resp_t;
endpackage : pwmcc_pkg

// File: verilog/pwmcc_div_if.sv
// settings and tick of one divided clock, between control and divider
interface pwmcc_div_if;
  import pwmcc_pkg::*;
  pwmcc_prescale_t prescale;
  pwmcc_factor_t   factor;
  logic            tick;
  modport ctrl (output prescale, output factor, input tick);
  modport div  (input prescale, input factor, output tick);
endinterface : pwmcc_div_if

// File: verilog/pwmcc_clkdiv.sv
// prescaler and divide-factor counter making one divided-clock enable pulse
`include "pwmcc_consts.svh"
module pwmcc_clkdiv (
  input  wire logic  mclk_i,
  input  wire logic  rst_i,
  pwmcc_div_if.div   div
);
  import pwmcc_pkg::*;

  pwmcc_pre_cnt_t pre_cnt_reg;
  pwmcc_pre_cnt_t pre_cnt_next;
  pwmcc_factor_t  div_cnt_reg;
  pwmcc_factor_t  div_cnt_next;
  logic           tick_reg;
  logic           tick_next;
  pwmcc_pre_cnt_t pre_mask;
  logic           pre_tick;

  always_comb begin
    pre_cnt_next = pre_cnt_reg + pwmcc_pre_cnt_t'(1);
    // master clock divided by two to the power of the code; reserved codes stall
    pre_mask     = pwmcc_pre_cnt_t'((11'h001 << div.prescale) - 11'h001);
    pre_tick     = (div.prescale <= `PWMCC_PRE_MAX) && ((pre_cnt_reg & pre_mask) == pre_mask);
    div_cnt_next = div_cnt_reg;
    tick_next    = 1'b0;
    if (div.factor == '0) begin
      div_cnt_next = '0;
      tick_next    = 1'b0;
    end else if (pre_tick) begin
      if (div_cnt_reg >= div.factor - pwmcc_factor_t'(1)) begin
        div_cnt_next = '0;
        tick_next    = 1'b1;
      end else begin
        div_cnt_next = div_cnt_reg + pwmcc_factor_t'(1);
      end
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt_reg <= '0;
      div_cnt_reg <= '0;
      tick_reg    <= 1'b0;
    end else begin
      pre_cnt_reg <= pre_cnt_next;
      div_cnt_reg <= div_cnt_next;
      tick_reg    <= tick_next;
    end
  end

  assign div.tick = tick_reg;
endmodule : pwmcc_clkdiv

// File: verilog/pwmcc_top.sv
// pwm clock generator and channel enable/interrupt control with an axi4-lite slave
`include "pwmcc_consts.svh"
module pwmcc_top #(
  parameter int NUM_CH = 4,
  parameter int ADDR_W = 8
) (
  input  wire logic                  mclk_i,
  input  wire logic                  rst_i,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire pwmcc_pkg::pwmcc_word_t s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output pwmcc_pkg::pwmcc_resp_t     s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output pwmcc_pkg::pwmcc_word_t     s_axi_rdata_o,
  output pwmcc_pkg::pwmcc_resp_t     s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  input  wire logic [NUM_CH-1:0]     period_end_i,
  output logic                       clk_a_tick_o,
  output logic                       clk_b_tick_o,
  output logic [NUM_CH-1:0]          chan_enable_o,
  output logic [NUM_CH-1:0]          chan_irq_o
);
  import pwmcc_pkg::*;

  if (NUM_CH < 1 || NUM_CH > 8) begin : g_bad_num_ch
    $error("NUM_CH must lie between 1 and 8");
  end
  if (ADDR_W < 8) begin : g_bad_addr_w
    $error("ADDR_W must be at least 8");
  end

  // divided clocks a and b
  pwmcc_word_t       mr_reg;
  pwmcc_word_t       mr_next;
  pwmcc_div_if div_if [2] ();

  assign div_if[0].factor   = mr_reg[`PWMCC_FACT_A_LSB +: `PWMCC_FACTOR_W];
  assign div_if[0].prescale = mr_reg[`PWMCC_PRE_A_LSB +: `PWMCC_PRESCALE_W];
  assign div_if[1].factor   = mr_reg[`PWMCC_FACT_B_LSB +: `PWMCC_FACTOR_W];
  assign div_if[1].prescale = mr_reg[`PWMCC_PRE_B_LSB +: `PWMCC_PRESCALE_W];

  for (genvar g = 0; g < 2; g++) begin : g_div
    pwmcc_clkdiv u_div (
      .mclk_i (mclk_i),
      .rst_i  (rst_i),
      .div    (div_if[g].div)
    );
  end

  assign clk_a_tick_o = div_if[0].tick;
  assign clk_b_tick_o = div_if[1].tick;

  // register and bus state
  logic [NUM_CH-1:0] chen_reg;
  logic [NUM_CH-1:0] chen_next;
  logic [NUM_CH-1:0] imr_reg;
  logic [NUM_CH-1:0] imr_next;
  logic [NUM_CH-1:0] flags_reg;
  logic [NUM_CH-1:0] flags_next;
  logic [NUM_CH-1:0] irq_reg;
  logic [NUM_CH-1:0] irq_next;

  logic              aw_hold_reg;
  logic              aw_hold_next;
  logic [7:0]        awaddr_reg;
  logic [7:0]        awaddr_next;
  logic              w_hold_reg;
  logic              w_hold_next;
  pwmcc_word_t       wdata_reg;
  pwmcc_word_t       wdata_next;
  logic [3:0]        wstrb_reg;
  logic [3:0]        wstrb_next;
  logic              awready_reg;
  logic              awready_next;
  logic              wready_reg;
  logic              wready_next;
  logic              bvalid_reg;
  logic              bvalid_next;
  pwmcc_resp_t       bresp_reg;
  pwmcc_resp_t       bresp_next;
  logic              arready_reg;
  logic              arready_next;
  logic              rvalid_reg;
  logic              rvalid_next;
  pwmcc_word_t       rdata_reg;
  pwmcc_word_t       rdata_next;
  pwmcc_resp_t       rresp_reg;
  pwmcc_resp_t       rresp_next;

  logic              do_write;
  logic              do_read;
  logic [7:0]        raddr;
  logic [NUM_CH-1:0] wr_bits;
  logic [NUM_CH-1:0] rd_clear;
  pwmcc_word_t       byte_mask;

  always_comb begin
    mr_next      = mr_reg;
    chen_next    = chen_reg;
    imr_next     = imr_reg;
    aw_hold_next = aw_hold_reg;
    awaddr_next  = awaddr_reg;
    w_hold_next  = w_hold_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    rd_clear     = '0;
    raddr        = s_axi_araddr_i[7:0];
    wr_bits      = wdata_reg[NUM_CH-1:0] & {NUM_CH{wstrb_reg[0]}};
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{wstrb_reg[i]}};
    end

    // address and data are taken in either order
    if (s_axi_awvalid_i && awready_reg) begin
      aw_hold_next = 1'b1;
      awaddr_next  = s_axi_awaddr_i[7:0];
    end
    if (s_axi_wvalid_i && wready_reg) begin
      w_hold_next = 1'b1;
      wdata_next  = s_axi_wdata_i;
      wstrb_next  = s_axi_wstrb_i;
    end

    do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    if (do_write) begin
      aw_hold_next = 1'b0;
      w_hold_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = `PWMCC_RESP_OKAY;
      if (awaddr_reg == `PWMCC_OFF_MR) begin
        mr_next = ((mr_reg & ~byte_mask) | (wdata_reg & byte_mask)) & `PWMCC_MR_MASK;
      end else if (awaddr_reg == `PWMCC_OFF_ENA) begin
        chen_next = chen_reg | wr_bits;
      end else if (awaddr_reg == `PWMCC_OFF_DIS) begin
        chen_next = chen_reg & ~wr_bits;
      end else if (awaddr_reg == `PWMCC_OFF_IER) begin
        imr_next = imr_reg | wr_bits;
      end else if (awaddr_reg == `PWMCC_OFF_IDR) begin
        imr_next = imr_reg & ~wr_bits;
      end else if (awaddr_reg == `PWMCC_OFF_SR || awaddr_reg == `PWMCC_OFF_IMR
                   || awaddr_reg == `PWMCC_OFF_ISR) begin
        bresp_next = `PWMCC_RESP_OKAY;
      end else begin
        bresp_next = `PWMCC_RESP_SLVERR;
      end
    end
    if (bvalid_reg && s_axi_bready_i) begin
      bvalid_next = 1'b0;
    end

    do_read = s_axi_arvalid_i && arready_reg;
    if (rvalid_reg && s_axi_rready_i) begin
      rvalid_next = 1'b0;
    end
    if (do_read) begin
      rvalid_next = 1'b1;
      rresp_next  = `PWMCC_RESP_OKAY;
      rdata_next  = '0;
      if (raddr == `PWMCC_OFF_MR) begin
        rdata_next = mr_reg;
      end else if (raddr == `PWMCC_OFF_SR) begin
        rdata_next[NUM_CH-1:0] = chen_reg;
      end else if (raddr == `PWMCC_OFF_IMR) begin
        rdata_next[NUM_CH-1:0] = imr_reg;
      end else if (raddr == `PWMCC_OFF_ISR) begin
        rdata_next[NUM_CH-1:0] = flags_reg;
        rd_clear               = flags_reg;
      end else if (raddr == `PWMCC_OFF_ENA || raddr == `PWMCC_OFF_DIS
                   || raddr == `PWMCC_OFF_IER || raddr == `PWMCC_OFF_IDR) begin
        rdata_next = '0;
      end else begin
        rresp_next = `PWMCC_RESP_SLVERR;
      end
    end

    // a period end in the clearing cycle survives the read
    flags_next   = (flags_reg & ~rd_clear) | period_end_i;
    irq_next     = flags_next & imr_next;
    awready_next = !aw_hold_next && !bvalid_next;
    wready_next  = !w_hold_next && !bvalid_next;
    arready_next = !rvalid_next;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      mr_reg      <= `PWMCC_MR_RST;
      chen_reg    <= NUM_CH'(`PWMCC_CH_RST);
      imr_reg     <= NUM_CH'(`PWMCC_CH_RST);
      flags_reg   <= NUM_CH'(`PWMCC_CH_RST);
      irq_reg     <= NUM_CH'(`PWMCC_CH_RST);
      aw_hold_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_hold_reg  <= 1'b0;
      wdata_reg   <= '0;
      wstrb_reg   <= '0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PWMCC_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= `PWMCC_RESP_OKAY;
    end else begin
      mr_reg      <= mr_next;
      chen_reg    <= chen_next;
      imr_reg     <= imr_next;
      flags_reg   <= flags_next;
      irq_reg     <= irq_next;
      aw_hold_reg <= aw_hold_next;
      awaddr_reg  <= awaddr_next;
      w_hold_reg  <= w_hold_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = arready_reg;
  assign s_axi_rvalid_o  = rvalid_reg;
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;
  assign chan_enable_o   = chen_reg;
  assign chan_irq_o      = irq_reg;
endmodule : pwmcc_top

// File: verification/pwmcc_monitor.sv
// concurrent checks on the pwm clock and channel control top ports
`include "pwmcc_consts.svh"
module pwmcc_monitor #(
  parameter int NUM_CH = 4,
  parameter int ADDR_W = 8
) (
  input wire logic                   mclk_i,
  input wire logic                   rst_i,
  input wire logic [ADDR_W-1:0]      s_axi_awaddr_i,
  input wire logic                   s_axi_awvalid_i,
  input wire logic                   s_axi_awready_o,
  input wire pwmcc_pkg::pwmcc_word_t s_axi_wdata_i,
  input wire logic [3:0]             s_axi_wstrb_i,
  input wire logic                   s_axi_wvalid_i,
  input wire logic                   s_axi_wready_o,
  input wire pwmcc_pkg::pwmcc_resp_t s_axi_bresp_o,
  input wire logic                   s_axi_bvalid_o,
  input wire logic [ADDR_W-1:0]      s_axi_araddr_i,
  input wire logic                   s_axi_arvalid_i,
  input wire logic                   s_axi_arready_o,
  input wire pwmcc_pkg::pwmcc_word_t s_axi_rdata_o,
  input wire logic                   s_axi_rvalid_o,
  input wire logic [NUM_CH-1:0]      period_end_i,
  input wire logic [NUM_CH-1:0]      chan_enable_o,
  input wire logic [NUM_CH-1:0]      chan_irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import pwmcc_pkg::*;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic wr_hs;
  logic rd_hs;
  assign wr_hs = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
                 && s_axi_wstrb_i[0];
  assign rd_hs = s_axi_arvalid_i && s_axi_arready_o;
  // flag read taken with no period end around it
  sequence isr_read_quiet;
    rd_hs && s_axi_araddr_i == `PWMCC_OFF_ISR && !(|period_end_i) ##1 !(|period_end_i);
  endsequence
  chk_write_answer: assert property (wr_hs |-> ##2 s_axi_bvalid_o)
    else $error("write response missing");
  chk_read_answer: assert property (rd_hs |=> s_axi_rvalid_o)
    else $error("read response missing");
  chk_mapped_okay: assert property (wr_hs && s_axi_awaddr_i[7:0] <= `PWMCC_OFF_ISR
    && s_axi_awaddr_i[1:0] == 2'h0
    |-> ##2 s_axi_bresp_o == `PWMCC_RESP_OKAY) else $error("mapped write not okay");
  chk_unmapped_err: assert property (wr_hs && (s_axi_awaddr_i[7:0] > `PWMCC_OFF_ISR
    || s_axi_awaddr_i[1:0] != 2'h0)
    |-> ##2 s_axi_bresp_o == `PWMCC_RESP_SLVERR) else $error("unmapped write not error");
  chk_enable_sets: assert property (wr_hs && s_axi_awaddr_i == `PWMCC_OFF_ENA |-> ##2
    chan_enable_o == ($past(chan_enable_o, 2) | $past(s_axi_wdata_i[NUM_CH-1:0], 2)))
    else $error("enable strobe wrong");
  chk_disable_clears: assert property (wr_hs && s_axi_awaddr_i == `PWMCC_OFF_DIS |-> ##2
    chan_enable_o == ($past(chan_enable_o, 2) & ~$past(s_axi_wdata_i[NUM_CH-1:0], 2)))
    else $error("disable strobe wrong");
  chk_status_view: assert property (rd_hs && s_axi_araddr_i == `PWMCC_OFF_SR |=>
    s_axi_rdata_o[NUM_CH-1:0] == $past(chan_enable_o)) else $error("status read wrong");
  chk_isr_clears: assert property (isr_read_quiet |=> chan_irq_o == '0)
    else $error("interrupt kept after flag read");
endmodule : pwmcc_monitor

// File: verification/pwmcc_load_model.sv
// far side: channel counters ending a period every few clock a ticks
module pwmcc_load_model #(
  parameter int TICKS = 3
) (
  input  wire logic       mclk_i,
  input  wire logic       rst_i,
  input  wire logic       tick_i,
  input  wire logic [3:0] enable_i,
  output logic      [3:0] period_end_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg;
  logic [7:0] cnt_next;
  logic [3:0] pend_reg;
  logic [3:0] pend_next;
  logic       wrap;
  assign wrap = tick_i && cnt_reg == 8'(TICKS - 1);
  assign period_end_o = pend_reg;
  always_comb begin
    cnt_next = wrap ? 8'h00 : cnt_reg + {7'h00, tick_i};
    pend_next = wrap ? enable_i : 4'h0;
  end
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_reg <= 8'h00;
      pend_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
      pend_reg <= pend_next;
    end
  end
endmodule : pwmcc_load_model

// File: verification/testbench.sv
// self-checking bench for the pwm clock and channel control block
`include "pwmcc_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import pwmcc_pkg::*;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  awaddr = 8'h00;
  logic [7:0]  araddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  pwmcc_word_t wdata = 32'h0;
  pwmcc_word_t rdata;
  pwmcc_resp_t bresp, rresp;
  logic        awready, wready, bvalid, arready, rvalid, tick_a, tick_b;
  logic [3:0]  pend, chen, irq;
  int          miscompares = 0;
  int          num_checks = 0;
  always #5 mclk_i = ~mclk_i;
  pwmcc_top i_dut (.mclk_i, .rst_i, .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .period_end_i(pend), .clk_a_tick_o(tick_a), .clk_b_tick_o(tick_b),
    .chan_enable_o(chen), .chan_irq_o(irq));
  pwmcc_load_model i_load (.mclk_i, .rst_i, .tick_i(tick_a), .enable_i(chen),
    .period_end_o(pend));
  task automatic chk(input string n, input pwmcc_word_t e, input pwmcc_word_t g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    if (miscompares == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  // one bus write (w=1) or read (w=0); on a read d is the expected data
  task automatic xfer(input logic w, input logic [7:0] a, input pwmcc_word_t d,
                      input pwmcc_resp_t r = `PWMCC_RESP_OKAY);
    logic [2:0]  p, s;
    pwmcc_word_t v;
    pwmcc_resp_t rs;
    p = {1'b1, w, 1'b1};
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    bready <= w;
    arvalid <= !w;
    rready <= !w;
    while (p[0]) begin
      @(negedge mclk_i);
      s = w ? {awready, wready, bvalid} : {arready, 1'b0, rvalid};
      v = rdata;
      rs = w ? bresp : rresp;
      @(posedge mclk_i);
      if (p[2] && s[2]) awvalid <= 1'b0;
      if (p[2] && s[2]) arvalid <= 1'b0;
      if (p[1] && s[1]) wvalid <= 1'b0;
      p[2:1] = p[2:1] & ~s[2:1];
      if (s[0]) begin
        p[0] = 1'b0;
        bready <= 1'b0;
        rready <= 1'b0;
        if (!w && r == `PWMCC_RESP_OKAY) chk("read data", d, v);
        chk("response", 32'(r), 32'(rs));
      end
    end
    @(posedge mclk_i);
  endtask : xfer
  task automatic step(input logic [7:0] a, input pwmcc_word_t d, input logic [7:0] ra,
                      input pwmcc_word_t e);
    xfer(1'b1, a, d);
    xfer(1'b0, ra, e);
    if (ra == `PWMCC_OFF_SR) chk("channel enable", e, {28'h0, chen});
  endtask : step
  task automatic check_period(input logic sb, input logic [3:0] p, input logic [7:0] f,
                              input int e);
    int k;
    int gap;
    k = 0;
    gap = 0;
    xfer(1'b1, `PWMCC_OFF_MR, sb ? {4'h0, p, f, 16'h0000} : {20'h00000, p, f});
    for (int n = 0; n < 3200 && k < 3; n++) begin
      @(negedge mclk_i);
      if (k > 1) gap++;
      if (sb ? tick_b : tick_a) k++;
    end
    chk("tick count", e ? 3 : 0, k);
    chk("tick gap", e, gap);
    @(posedge mclk_i);
  endtask : check_period
  task automatic t_regs;
    xfer(1'b0, `PWMCC_OFF_MR, `PWMCC_MR_RST);
    xfer(1'b0, `PWMCC_OFF_IMR, 32'h0);
    xfer(1'b0, `PWMCC_OFF_ISR, 32'h0);
    step(`PWMCC_OFF_MR, 32'hFFFFFFFF, `PWMCC_OFF_MR, `PWMCC_MR_MASK);
    step(`PWMCC_OFF_SR, 32'hF, `PWMCC_OFF_SR, 32'h0);
    xfer(1'b1, 8'h40, 32'hF, `PWMCC_RESP_SLVERR);
    xfer(1'b0, 8'h40, 32'h0, `PWMCC_RESP_SLVERR);
    xfer(1'b0, `PWMCC_OFF_ENA, 32'h0);
  endtask : t_regs
  task automatic t_chan;
    step(`PWMCC_OFF_ENA, 32'h5, `PWMCC_OFF_SR, 32'h5);
    step(`PWMCC_OFF_ENA, 32'h2, `PWMCC_OFF_SR, 32'h7);
    step(`PWMCC_OFF_DIS, 32'h4, `PWMCC_OFF_SR, 32'h3);
    step(`PWMCC_OFF_DIS, 32'h0, `PWMCC_OFF_SR, 32'h3);
    step(`PWMCC_OFF_DIS, 32'hF, `PWMCC_OFF_SR, 32'h0);
  endtask : t_chan
  task automatic t_irq_mask;
    step(`PWMCC_OFF_IER, 32'h9, `PWMCC_OFF_IMR, 32'h9);
    step(`PWMCC_OFF_IER, 32'h2, `PWMCC_OFF_IMR, 32'hB);
    step(`PWMCC_OFF_IDR, 32'h8, `PWMCC_OFF_IMR, 32'h3);
    step(`PWMCC_OFF_IDR, 32'h0, `PWMCC_OFF_IMR, 32'h3);
  endtask : t_irq_mask
  task automatic t_flags;
    xfer(1'b1, `PWMCC_OFF_ENA, 32'h5);
    xfer(1'b1, `PWMCC_OFF_MR, 32'h00000001);
    repeat (20) @(posedge mclk_i);
    xfer(1'b1, `PWMCC_OFF_MR, 32'h0);
    repeat (8) @(posedge mclk_i);
    chk("interrupt", 32'h1, {28'h0, irq});
    xfer(1'b0, `PWMCC_OFF_ISR, 32'h5);
    xfer(1'b0, `PWMCC_OFF_ISR, 32'h0);
    chk("interrupt", 32'h0, {28'h0, irq});
  endtask : t_flags
  task automatic t_clocks;
    check_period(1'b0, 4'h0, 8'h00, 0);
    check_period(1'b1, 4'h0, 8'h00, 0);
    for (int c = 0; c <= 10; c++) check_period(1'b0, 4'(c), 8'h01, 1 << c);
    check_period(1'b1, 4'hA, 8'h01, 1024);
    check_period(1'b0, 4'hB, 8'h01, 0);
    check_period(1'b1, 4'hF, 8'h01, 0);
    check_period(1'b1, 4'h1, 8'h02, 4);
    check_period(1'b0, 4'h0, 8'hFF, 255);
    check_period(1'b1, 4'h3, 8'h03, 24);
  endtask : t_clocks
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    t_regs();
    t_chan();
    t_irq_mask();
    t_flags();
    t_clocks();
    tally_and_finish();
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    miscompares++;
    tally_and_finish();
  end
endmodule : testbench
bind pwmcc_top pwmcc_monitor #(.NUM_CH(NUM_CH), .ADDR_W(ADDR_W)) i_mon (.mclk_i, .rst_i,
  .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_araddr_i,
  .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o, .period_end_i,
  .chan_enable_o, .chan_irq_o);
